// >>> tcfg_consts.vh
`ifndef TCFG_CONSTS_VH
`define TCFG_CONSTS_VH
`define TCFG_I2C_ADDR       7'h00
`define TCFG_SUB_LANE       8'h00
`define TCFG_SUB_CHSUM      8'h01
`define TCFG_SUB_PAYEN      8'h02
`define TCFG_SUB_ALIGN      8'h03
`define TCFG_SUB_TEMP       8'h04
`define TCFG_SUB_VINT       8'h05
`define TCFG_SUB_ENGCTRL    8'h06
`define TCFG_SUB_ERASE      8'h07
`define TCFG_SUB_SWDATA     8'h08
`define TCFG_SUB_SADDRLO    8'h09
`define TCFG_SUB_SACC       8'h0A
`define TCFG_SUB_SRDATA     8'h0B
`define TCFG_SUB_READY      8'h11
`define TCFG_PAYEN_MASK     16'h5540
`define TCFG_ALIGN_MASK     16'h000A
`define TCFG_ENG_MASK       16'h07F8
`define TCFG_ERASE_MASK     16'h03FF
`define TCFG_SACC_MASK      16'hC03F
`define TCFG_BIT_EXEC       8
`define TCFG_BIT_SRAMSEL    7
`define TCFG_BIT_ALIGN      3
`define TCFG_BIT_SWR        15
`define TCFG_BIT_SRD        14
`define TCFG_BIT_READY      15
`define TCFG_TGT_MASTER     2'h1
`define TCFG_TGT_SECOND     2'h2
`define TCFG_TGT_THIRD      2'h3
`define TCFG_OP_LAST        4'hB
`define TCFG_SRAM_AW        22
`endif

// >>> tcfg_register_file.v
`timescale 1ns/1ps
`default_nettype none
`include "tcfg_consts.vh"
module tcfg_register_file
(
   // Clock and reset.
   input  wire        sys_clk,
   input  wire        reset,
   // I2C pins; output enable low while driving low.
   input  wire        sclIn,
   input  wire        sdaIn,
   output wire        sdaOut,
   output wire        sdaOe_n,
   // Status inputs from the transceivers and monitors.
   input  wire [9:0]  laneUp,
   input  wire [4:0]  channelUp,
   input  wire [15:0] dieTemp,
   input  wire [15:0] coreSupply,
   input  wire [14:0] fwVersion,
   input  wire        syncIn,
   // Controls to the payload logic.
   output reg  [4:0]  payloadEnable,
   output reg         alignEnable,
   output reg         initAllLinks,
   output reg         alignStrobe,
   // Configuration engine handshake.
   output reg         engineStart,
   output reg  [1:0]  engineTarget,
   output reg  [3:0]  engineOpcode,
   output reg  [9:0]  engineEraseBlock,
   output reg         sramHostOwned,
   input  wire        engineDone
);
   reg [2:0]  sclSync;
   reg [2:0]  sdaSync;
   reg [1:0]  syncSync;
   reg        syncLast;
   wire       sclRise = sclSync[1] & ~sclSync[2];
   wire       sclFall = ~sclSync[1] & sclSync[2];
   wire       startCond = sclSync[1] & sdaSync[2] & ~sdaSync[1];
   wire       stopCond = sclSync[1] & ~sdaSync[2] & sdaSync[1];

   localparam ST_IDLE = 3'h0;
   localparam ST_ADDR = 3'h1;
   localparam ST_ACK  = 3'h2;
   localparam ST_WR   = 3'h3;
   localparam ST_RD   = 3'h4;
   localparam ST_RACK = 3'h5;

   reg [2:0]  state;
   reg [2:0]  bitCnt;
   reg [7:0]  shiftIn;
   reg [7:0]  shiftOut;
   reg [1:0]  byteIdx;
   reg        isRead;
   reg        driveLow;
   reg [7:0]  subAddr;
   reg [7:0]  wrHigh;
   reg [15:0] rdWord;
   reg        gotByte;

   reg [15:0] engCtrl;
   reg [15:0] sramWrData;
   reg [15:0] sramAddrLo;
   reg [15:0] sramAccess;
   reg [15:0] sramRdData;
   reg        engBusy;
   reg        execLast;
   reg        swrLast;
   reg        srdLast;
   reg [15:0] sram [0:(1<<`TCFG_SRAM_AW)-1];

   wire [`TCFG_SRAM_AW-1:0] sramAddr = {sramAccess[5:0], sramAddrLo};
   wire [15:0] laneWord = {channelUp[3:0], 2'h0, laneUp};
   wire [15:0] sumWord = {14'h0000, &channelUp, channelUp[4]};
   wire [15:0] readyWord = {~engBusy, fwVersion};

   reg        wrStrobe;
   reg [15:0] wrWord;

   assign sdaOut = 1'b0;
   assign sdaOe_n = ~driveLow;

   // Register read selection; unmapped addresses return zero.
   always @*
   begin
      case (subAddr)
         `TCFG_SUB_LANE:    rdWord = laneWord;
         `TCFG_SUB_CHSUM:   rdWord = sumWord;
         `TCFG_SUB_PAYEN:   rdWord = {1'b0, payloadEnable[4], 1'b0,
                                      payloadEnable[3], 1'b0,
                                      payloadEnable[2], 1'b0,
                                      payloadEnable[1], 1'b0,
                                      payloadEnable[0], 6'h00};
         `TCFG_SUB_ALIGN:   rdWord = {12'h000, alignEnable, 1'b0,
                                      initAllLinks, 1'b0};
         `TCFG_SUB_TEMP:    rdWord = dieTemp;
         `TCFG_SUB_VINT:    rdWord = coreSupply;
         `TCFG_SUB_ENGCTRL: rdWord = engCtrl;
         `TCFG_SUB_ERASE:   rdWord = {6'h00, engineEraseBlock};
         `TCFG_SUB_SWDATA:  rdWord = sramWrData;
         `TCFG_SUB_SADDRLO: rdWord = sramAddrLo;
         `TCFG_SUB_SACC:    rdWord = sramAccess;
         `TCFG_SUB_SRDATA:  rdWord = sramRdData;
         `TCFG_SUB_READY:   rdWord = readyWord;
         default:           rdWord = 16'h0000;
      endcase
   end

   // Input synchronisers.
   always @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         sclSync <= 3'h7;
         sdaSync <= 3'h7;
         syncSync <= 2'h0;
         syncLast <= 1'b0;
      end
      else
      begin
         sclSync <= {sclSync[1:0], sclIn};
         sdaSync <= {sdaSync[1:0], sdaIn};
         syncSync <= {syncSync[0], syncIn};
         syncLast <= syncSync[1];
      end
   end

   // I2C slave: address, sub-address, then 16-bit words high byte first.
   always @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         state <= ST_IDLE;
         bitCnt <= 3'h0;
         shiftIn <= 8'h00;
         shiftOut <= 8'h00;
         byteIdx <= 2'h0;
         isRead <= 1'b0;
         driveLow <= 1'b0;
         subAddr <= 8'h00;
         wrHigh <= 8'h00;
         wrStrobe <= 1'b0;
         wrWord <= 16'h0000;
         gotByte <= 1'b0;
      end
      else
      begin
         wrStrobe <= 1'b0;
         if (startCond)
         begin
            state <= ST_ADDR;
            bitCnt <= 3'h0;
            gotByte <= 1'b0;
            byteIdx <= 2'h0;
            driveLow <= 1'b0;
         end
         else if (stopCond)
         begin
            state <= ST_IDLE;
            driveLow <= 1'b0;
         end
         else
         begin
            case (state)
               ST_ADDR, ST_WR:
               begin
                  if (sclRise)
                  begin
                     shiftIn <= {shiftIn[6:0], sdaSync[1]};
                     bitCnt <= bitCnt + 3'h1;
                     gotByte <= (bitCnt == 3'h7);
                  end
                  if (sclFall && gotByte)
                  begin
                     gotByte <= 1'b0;
                     if (state == ST_ADDR)
                     begin
                        if (shiftIn[7:1] == `TCFG_I2C_ADDR)
                        begin
                           isRead <= shiftIn[0];
                           byteIdx <= 2'h3;
                           driveLow <= 1'b1;
                           state <= ST_ACK;
                        end
                        else
                           state <= ST_IDLE;
                     end
                     else
                     begin
                        driveLow <= 1'b1;
                        state <= ST_ACK;
                        if (byteIdx == 2'h0)
                           subAddr <= shiftIn;
                        else if (byteIdx == 2'h1)
                           wrHigh <= shiftIn;
                        else
                        begin
                           wrWord <= {wrHigh, shiftIn};
                           wrStrobe <= 1'b1;
                        end
                     end
                  end
               end
               ST_ACK:
               begin
                  if (sclFall)
                  begin
                     driveLow <= 1'b0;
                     bitCnt <= 3'h0;
                     if (isRead)
                     begin
                        shiftOut <= rdWord[15:8];
                        byteIdx <= 2'h1;
                        driveLow <= ~rdWord[15];
                        state <= ST_RD;
                        isRead <= 1'b0;
                     end
                     else
                     begin
                        byteIdx <= (byteIdx == 2'h2) ? 2'h1
                                   : byteIdx + 2'h1;
                        if (byteIdx == 2'h2)
                           subAddr <= subAddr + 8'h01;
                        state <= ST_WR;
                     end
                  end
               end
               ST_RD:
               begin
                  if (sclFall)
                  begin
                     bitCnt <= bitCnt + 3'h1;
                     if (bitCnt == 3'h7)
                     begin
                        driveLow <= 1'b0;
                        state <= ST_RACK;
                        if (!byteIdx[0])
                           subAddr <= subAddr + 8'h01;
                     end
                     else
                     begin
                        shiftOut <= {shiftOut[6:0], 1'b0};
                        driveLow <= ~shiftOut[6];
                     end
                  end
               end
               ST_RACK:
               begin
                  if (sclRise && sdaSync[1])
                     state <= ST_IDLE;
                  else if (sclFall)
                  begin
                     bitCnt <= 3'h0;
                     shiftOut <= byteIdx[0] ? rdWord[7:0] : rdWord[15:8];
                     driveLow <= byteIdx[0] ? ~rdWord[7] : ~rdWord[15];
                     byteIdx <= {1'b0, ~byteIdx[0]};
                     state <= ST_RD;
                  end
               end
               default:
                  state <= ST_IDLE;
            endcase
         end
      end
   end

   // Register writes, edge detection and engine control.
   always @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         payloadEnable <= 5'h00;
         alignEnable <= 1'b0;
         initAllLinks <= 1'b0;
         alignStrobe <= 1'b0;
         engCtrl <= 16'h0000;
         engineEraseBlock <= 10'h000;
         sramWrData <= 16'h0000;
         sramAddrLo <= 16'h0000;
         sramAccess <= 16'h0000;
         sramRdData <= 16'h0000;
         engBusy <= 1'b0;
         execLast <= 1'b0;
         swrLast <= 1'b0;
         srdLast <= 1'b0;
         engineStart <= 1'b0;
         engineTarget <= 2'h0;
         engineOpcode <= 4'h0;
         sramHostOwned <= 1'b0;
      end
      else
      begin
         engineStart <= 1'b0;
         alignStrobe <= alignEnable & syncLast & ~syncSync[1];
         if (wrStrobe)
         begin
            case (subAddr)
               `TCFG_SUB_PAYEN:
                  payloadEnable <= {wrWord[14], wrWord[12], wrWord[10],
                                    wrWord[8], wrWord[6]};
               `TCFG_SUB_ALIGN:
               begin
                  alignEnable <= wrWord[`TCFG_BIT_ALIGN];
                  initAllLinks <= wrWord[1];
               end
               `TCFG_SUB_ENGCTRL:
                  engCtrl <= wrWord & `TCFG_ENG_MASK;
               `TCFG_SUB_ERASE:
                  engineEraseBlock <= wrWord[9:0];
               `TCFG_SUB_SWDATA:
                  sramWrData <= wrWord;
               `TCFG_SUB_SADDRLO:
                  sramAddrLo <= wrWord;
               `TCFG_SUB_SACC:
                  sramAccess <= wrWord & `TCFG_SACC_MASK;
               default:
                  sramAccess <= sramAccess;
            endcase
         end
         sramHostOwned <= engCtrl[`TCFG_BIT_SRAMSEL];
         execLast <= engCtrl[`TCFG_BIT_EXEC];
         swrLast <= sramAccess[`TCFG_BIT_SWR];
         srdLast <= sramAccess[`TCFG_BIT_SRD];
         if (engCtrl[`TCFG_BIT_EXEC] && !execLast && !engBusy)
         begin
            if (engCtrl[10:9] != 2'h0 && engCtrl[6:3] <= `TCFG_OP_LAST)
            begin
               engineTarget <= engCtrl[10:9];
               engineOpcode <= engCtrl[6:3];
               engineStart <= 1'b1;
               engBusy <= 1'b1;
            end
         end
         else if (engBusy && engineDone && !engineStart)
            engBusy <= 1'b0;
         if (sramAccess[`TCFG_BIT_SWR] && !swrLast && sramHostOwned)
            sram[sramAddr] <= sramWrData;
         if (sramAccess[`TCFG_BIT_SRD] && !srdLast)
            sramRdData <= sram[sramAddr];
      end
   end
endmodule // tcfg_register_file
`default_nettype wire

// >>> tcfg_register_file_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcfg_consts.vh"
module tcfg_register_file_props
(
   // Clock and reset.
   input wire logic       sys_clk,
   input wire logic       reset,
   // Watched ports.
   input wire logic       sclIn,
   input wire logic       sdaOut,
   input wire logic       sdaOe_n,
   input wire logic       syncIn,
   input wire logic       alignEnable,
   input wire logic       alignStrobe,
   input wire logic       engineStart,
   input wire logic [1:0] engineTarget,
   input wire logic [3:0] engineOpcode,
   input wire logic       engineDone
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   // Tracks an accepted opcode until the engine reports completion.
   logic busyM;
   always @(posedge sys_clk or posedge reset)
      if (reset)
         busyM <= 1'b0;
      else if (engineStart)
         busyM <= 1'b1;
      else if (engineDone)
         busyM <= 1'b0;
   start_pulse_a : assert property (engineStart |=> !engineStart)
      else $error("Engine start lasted more than one cycle.");
   start_target_a : assert property (engineStart |-> engineTarget != 2'h0)
      else $error("Engine started with no target selected.");
   start_opcode_a : assert property (engineStart |-> engineOpcode <= `TCFG_OP_LAST)
      else $error("Engine started with an unassigned opcode.");
   start_idle_a : assert property (engineStart |-> !busyM)
      else $error("Engine started while still busy.");
   align_gate_a : assert property (alignStrobe |-> alignEnable && !syncIn)
      else $error("Alignment strobe without enable or sync low.");
   align_pulse_a : assert property (alignStrobe |=> !alignStrobe)
      else $error("Alignment strobe lasted more than one cycle.");
   align_reach_a : assert property (alignEnable && $fell(syncIn) |-> ##[1:6] alignStrobe)
      else $error("Sync fall gave no alignment strobe.");
   sda_change_a : assert property ($changed(sdaOe_n) |-> !sclIn)
      else $error("Data line changed while the bus clock was high.");
   sda_level_a : assert property (!sdaOe_n |-> sdaOut == 1'b0)
      else $error("Data line driven high.");
endmodule // tcfg_register_file_props
bind tcfg_register_file tcfg_register_file_props tcfg_register_file_props_i
   (.sys_clk, .reset, .sclIn, .sdaOut, .sdaOe_n, .syncIn, .alignEnable,
    .alignStrobe, .engineStart, .engineTarget, .engineOpcode, .engineDone);
`default_nettype wire

// >>> tcfg_i2c_master.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcfg_consts.vh"
module tcfg_i2c_master
(
   // Pacing clock and bus lines; the bus clock idles high between frames.
   input  wire logic sys_clk,
   input  wire logic sda,
   output var  logic scl,
   output var  logic sdaDrv
);
   integer nacks;
   initial
   begin
      scl = 1'b1;
      sdaDrv = 1'b1;
      nacks = 0;
   end
   task automatic w(input integer n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // One bit lasts eight clocks; data moves only while the bus clock is low.
   task automatic bitx(input logic b, output logic r);
      w(2);
      sdaDrv = b;
      w(2);
      scl = 1'b1;
      w(3);
      r = sda;
      w(1);
      scl = 1'b0;
   endtask
   task automatic start;
      w(2);
      sdaDrv = 1'b0;
      w(2);
      scl = 1'b0;
   endtask
   task automatic stop;
      w(2);
      sdaDrv = 1'b0;
      w(2);
      scl = 1'b1;
      w(2);
      sdaDrv = 1'b1;
      w(2);
   endtask
   task automatic octet(input logic [7:0] d, input logic ackIn,
                        output logic [7:0] q, output logic ackOut);
      integer i;
      for (i = 7; i >= 0; i = i - 1)
         bitx(d[i], q[i]);
      bitx(ackIn, ackOut);
   endtask
   task automatic put(input logic [7:0] d);
      logic [7:0] q;
      logic a;
      octet(d, 1'b1, q, a);
      if (a !== 1'b0)
         nacks = nacks + 1;
   endtask
   // Board address then sub-address, high byte before low byte.
   task automatic wr(input logic [7:0] sub, input logic [15:0] d);
      start();
      put({`TCFG_I2C_ADDR, 1'b0});
      put(sub);
      put(d[15:8]);
      put(d[7:0]);
      stop();
   endtask
   task automatic rd(input logic [7:0] sub, output logic [15:0] d);
      logic a;
      start();
      put({`TCFG_I2C_ADDR, 1'b0});
      put(sub);
      stop();
      start();
      put({`TCFG_I2C_ADDR, 1'b1});
      octet(8'hFF, 1'b0, d[15:8], a);
      octet(8'hFF, 1'b1, d[7:0], a);
      stop();
   endtask
endmodule // tcfg_i2c_master
`default_nettype wire

// >>> trigger_fpga_config_register_file_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module trigger_fpga_config_register_file_tb_top;
   logic        sys_clk, reset, syncIn, engineDone;
   logic [9:0]  laneUp;
   logic [4:0]  channelUp;
   logic [15:0] dieTemp, coreSupply, v, word;
   logic [14:0] fwVersion;
   logic [39:0] rows [0:12];
   logic [3:0]  op, opSeen;
   logic [1:0]  tg, tgSeen;
   integer      mismatches, total_checks, starts, aligns, doneDly, i, n;
   wire         scl, sdaDrv, sdaOut, sdaOe_n, alignEnable, initAllLinks;
   wire         alignStrobe, engineStart, sramHostOwned;
   wire [4:0]   payloadEnable;
   wire [1:0]   engineTarget;
   wire [3:0]   engineOpcode;
   wire [9:0]   engineEraseBlock;
   wire         sda = sdaDrv & (sdaOe_n | sdaOut);
   tcfg_register_file tcfg_register_file_i (.sys_clk, .reset, .sclIn(scl),
      .sdaIn(sda), .sdaOut, .sdaOe_n, .laneUp, .channelUp, .dieTemp,
      .coreSupply, .fwVersion, .syncIn, .payloadEnable, .alignEnable,
      .initAllLinks, .alignStrobe, .engineStart, .engineTarget, .engineOpcode,
      .engineEraseBlock, .sramHostOwned, .engineDone);
   tcfg_i2c_master tcfg_i2c_master_i (.sys_clk, .sda, .scl, .sdaDrv);
   always #20 sys_clk = ~sys_clk;
   always @(negedge sys_clk)
      if (engineStart === 1'b1)
         starts = starts + 1;
   always @(negedge sys_clk)
      if (alignStrobe === 1'b1)
         aligns = aligns + 1;
   // Stands in for the configuration engine: done follows a start later.
   initial
      forever
      begin
         @(negedge sys_clk);
         if (engineStart === 1'b1)
         begin
            opSeen = engineOpcode;
            tgSeen = engineTarget;
            repeat (doneDly) @(posedge sys_clk);
            #1 engineDone = 1'b1;
            @(posedge sys_clk);
            #1 engineDone = 1'b0;
         end
      end
   task tick(input integer k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask
   task wr(input logic [7:0] s, input logic [15:0] d);
      tcfg_i2c_master_i.wr(s, d);
   endtask
   task rd(input logic [7:0] s);
      tcfg_i2c_master_i.rd(s, v);
   endtask
   task check(input logic [15:0] got, input logic [15:0] exp);
      total_checks = total_checks + 1;
      if (got !== exp)
      begin
         mismatches = mismatches + 1;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task waitReady;
      rd(8'h11);
      for (n = 0; n < 30 && v[15] !== 1'b1; n = n + 1)
         rd(8'h11);
      check(v, {1'b1, fwVersion});
   endtask
   task syncPulse;
      syncIn = 1'b1;
      tick(30);
      syncIn = 1'b0;
      tick(10);
   endtask
   task print_verdict;
      $display("Comparisons %0d, mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      repeat (95000) @(posedge sys_clk);
      mismatches = mismatches + 1;
      print_verdict;
   end
   initial
   begin
      {sys_clk, reset, syncIn, engineDone} = 4'b0100;
      {mismatches, total_checks, starts, aligns, doneDly} = {32'd0, 32'd0, 96'd700};
      {laneUp, channelUp, fwVersion} = {10'h2A5, 5'h16, 15'h2C3A};
      {dieTemp, coreSupply} = {16'hBEEF, 16'h1357};
      rows = '{40'h00FFFF62A5, 40'h01FFFF0001, 40'h02FFFF5540, 40'h03FFFF000A,
               40'h04FFFFBEEF, 40'h05FFFF1357, 40'h06FFFF07F8, 40'h07FFFF03FF,
               40'h08A5C3A5C3, 40'h0912341234, 40'h0A003F003F, 40'h0CFFFF0000,
               40'h11FFFFAC3A};
      tick(3);
      reset = 1'b0;
      tick(4);
      check({10'h0, sdaOe_n, payloadEnable}, 16'h0020);
      for (i = 0; i < 13; i = i + 1)
      begin
         wr(rows[i][39:32], rows[i][31:16]);
         rd(rows[i][39:32]);
         check(v, rows[i][15:0]);
      end
      check(16'(starts), 16'h0000);
      check({9'h0, initAllLinks, alignEnable, payloadEnable}, 16'h007F);
      check({6'h0, engineEraseBlock}, 16'h03FF);
      check({15'h0, sramHostOwned}, 16'h0001);
      syncPulse;
      check(16'(aligns), 16'h0001);
      wr(8'h03, 16'h0000);
      syncPulse;
      check(16'(aligns), 16'h0001);
      channelUp = 5'h1F;
      rd(8'h01);
      check(v, 16'h0003);
      rd(8'h00);
      check(v, 16'hF2A5);
      wr(8'h06, 16'h0000);
      for (op = 4'h0; op <= 4'hB; op = op + 4'h1)
      begin
         tg = 2'(op % 4'h3) + 2'h1;
         word = {5'h0, tg, 1'b1, 1'b0, op, 3'h0};
         i = starts;
         wr(8'h06, word);
         rd(8'h11);
         check(v & 16'h8000, 16'h0000);
         waitReady;
         check({10'h0, tgSeen, opSeen}, {10'h0, tg, op});
         wr(8'h06, word);
         wr(8'h06, word & 16'hFEFF);
         check(16'(starts - i), 16'h0001);
      end
      i = starts;
      wr(8'h06, 16'h0100);
      wr(8'h06, 16'h0000);
      wr(8'h06, 16'h0360);
      wr(8'h06, 16'h0200);
      check(16'(starts - i), 16'h0000);
      doneDly = 2000;
      wr(8'h06, 16'h0300);
      wr(8'h06, 16'h0200);
      wr(8'h06, 16'h0300);
      waitReady;
      wr(8'h06, 16'h0200);
      check(16'(starts - i), 16'h0001);
      wr(8'h06, 16'h0080);
      wr(8'h08, 16'h1111);
      wr(8'h09, 16'h4321);
      wr(8'h0A, 16'h8005);
      wr(8'h0A, 16'h0005);
      wr(8'h08, 16'hC0DE);
      wr(8'h0A, 16'h8015);
      wr(8'h0A, 16'h4015);
      rd(8'h0B);
      check(v, 16'hC0DE);
      wr(8'h06, 16'h0000);
      wr(8'h08, 16'hBAD0);
      wr(8'h0A, 16'h8015);
      wr(8'h0A, 16'h4015);
      rd(8'h0B);
      check(v, 16'hC0DE);
      wr(8'h0A, 16'h0005);
      wr(8'h0A, 16'h4005);
      rd(8'h0B);
      check(v, 16'h1111);
      check(16'(tcfg_i2c_master_i.nacks), 16'h0000);
      reset = 1'b1;
      tick(2);
      reset = 1'b0;
      tick(4);
      rd(8'h02);
      check(v, 16'h0000);
      print_verdict;
   end
endmodule // trigger_fpga_config_register_file_tb_top
`default_nettype wire
